// file: rtl/host_link_event_statistics.v
// event selection and statistics counters of the host link
// assumes: event inputs synchronous to hclk, the link core clock
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`include "link_stats_regs.vh"
module host_link_event_statistics #(
  parameter CNT_W = 32
) (
  // ahb-lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // transmit side
  input  wire [1:0]  tx_dw,
  input  wire [1:0]  tx_hdr_dw,
  input  wire        tx_replay,
  input  wire        tx_pkt,
  input  wire [1:0]  tx_kind,
  input  wire        tx_func,
  input  wire [7:0]  tx_tag,
  input  wire        stall_fc,
  input  wire        stall_rb,
  input  wire [5:0]  retry_level,
  // receive side
  input  wire [1:0]  rx_dw,
  input  wire [1:0]  rx_hdr_dw,
  input  wire        rx_pkt,
  input  wire [2:0]  rx_kind,
  input  wire        rx_good,
  input  wire        rx_func,
  input  wire [7:0]  rx_tag,
  input  wire        rx_bad,
  // flow control credits
  input  wire [59:0] partner_credit,
  input  wire [47:0] local_credit,
  // status
  output reg         stats_enabled
);

  // tx_kind codes
  localparam K_CPL = 2'h0;
  localparam K_NP  = 2'h2;
  // rx_kind codes
  localparam R_CPL = 3'h0;
  localparam R_MSG = 3'h2;

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [31:0]       event_map;
  reg [27:0]       threshold;
  reg [5:0]        retry_th;
  reg [8:0]        func_tag;
  reg [CNT_W-1:0]  count [0:3];
  reg [15:0]       addr_q;
  reg              wr_q;
  reg              act_q;
  reg [4:0]        pc_below;
  reg [3:0]        lc_zero;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  wire       take  = hsel & htrans[1] & hready;
  wire       wr_go = act_q & wr_q;
  wire [1:0] cidx  = addr_q[3:2];
  wire       is_cnt = (addr_q[15:4] == `OFS_COUNT0 >> 4) & (addr_q[1:0] == 2'h0);

  // address phase capture and one wait state per transfer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= 16'h0000;
      wr_q      <= 1'b0;
      act_q     <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      act_q     <= take;
      hreadyout <= ~take;
      if (take) begin
        addr_q <= haddr[15:0];
        wr_q   <= hwrite;
      end
    end
  end

  // read data, unmapped reads zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `RST_REG;
    end else if (act_q & ~wr_q) begin
      if (addr_q == `OFS_EVENT_MAP)
        hrdata <= event_map;
      else if (addr_q == `OFS_THRESHOLD)
        hrdata <= {4'h0, threshold};
      else if (addr_q == `OFS_RETRY_TH)
        hrdata <= {16'h0000, retry_th, 10'h000};
      else if (addr_q == `OFS_FUNC_TAG)
        hrdata <= {23'h000000, func_tag};
      else if (addr_q == `OFS_LINK_CTRL_TWO)
        hrdata <= {31'h00000000, stats_enabled};
      else if (is_cnt)
        hrdata <= count[cidx];
      else
        hrdata <= 32'h00000000;
    end
  end

  // control register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_map     <= `RST_REG;
      threshold     <= 28'h0000000;
      retry_th      <= 6'h00;
      func_tag      <= 9'h000;
      stats_enabled <= 1'b0;
    end else if (wr_go) begin
      if (addr_q == `OFS_EVENT_MAP)
        event_map <= hwdata;
      else if (addr_q == `OFS_THRESHOLD)
        threshold <= {hwdata[27:16], 4'h0, hwdata[11:0]};
      else if (addr_q == `OFS_RETRY_TH)
        retry_th <= hwdata[15:10];
      else if (addr_q == `OFS_FUNC_TAG)
        func_tag <= hwdata[8:0];
      else if (addr_q == `OFS_LINK_CTRL_TWO)
        stats_enabled <= hwdata[0];
    end
  end

  // ****************************************************************
  // event conditions
  // ****************************************************************
  wire [11:0] th_a  = threshold[`TH_A_LSB +: 12];
  wire [11:0] th_b  = threshold[`TH_B_LSB +: 12];
  wire        tx_ok = tx_pkt & ~tx_replay;
  wire        tx_mm = tx_ok & (tx_kind != K_CPL);
  wire        rx_cpl_g = rx_pkt & rx_good & (rx_kind == R_CPL);
  wire        ft_tx = (tx_func == func_tag[`FT_FUNC]) & (tx_tag == func_tag[7:0]);
  wire        ft_rx = (rx_func == func_tag[`FT_FUNC]) & (rx_tag == func_tag[7:0]);
  wire [4:0]  pc_now;
  wire [3:0]  lc_now;

  // partner credits below threshold, header types use the first field
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_pc
      wire [11:0] th = (g == 1 || g == 4) ? th_b : th_a;
      assign pc_now[g] = partner_credit[g*12 +: 12] < th;
    end
    for (g = 0; g < 4; g = g + 1) begin : g_lc
      assign lc_now[g] = local_credit[g*12 +: 12] == 12'h000;
    end
  endgenerate

  // level history for crossing detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_below <= 5'h00;
      lc_zero  <= 4'h0;
    end else begin
      pc_below <= pc_now;
      lc_zero  <= lc_now;
    end
  end

  wire [4:0] pc_event = pc_now & ~pc_below;
  wire [3:0] lc_event = lc_now & ~lc_zero;

  // increment for one event code
  function [1:0] inc_of;
    input [7:0] code;
    begin
      inc_of = 2'h0;
      case (code)
        `EV_TX_DW:    inc_of = tx_replay ? 2'h0 : tx_dw;
        `EV_TX_PKT:   inc_of = {1'b0, tx_ok};
        `EV_TX_F0:    inc_of = {1'b0, tx_mm & ~tx_func};
        `EV_TX_F1:    inc_of = {1'b0, tx_mm & tx_func};
        `EV_TX_NP0:   inc_of = {1'b0, tx_ok & (tx_kind == K_NP) & ~tx_func};
        `EV_TX_NP1:   inc_of = {1'b0, tx_ok & (tx_kind == K_NP) & tx_func};
        `EV_TX_FT:    inc_of = {1'b0, tx_mm & ft_tx};
        `EV_RX_PKT:   inc_of = {1'b0, rx_pkt & (rx_kind != R_MSG)
                                & ((rx_kind != R_CPL) | rx_good)};
        `EV_RX_CPL0:  inc_of = {1'b0, rx_cpl_g & ~rx_func};
        `EV_RX_FT:    inc_of = {1'b0, rx_cpl_g & ft_rx};
        `EV_CLOCK:    inc_of = 2'h1;
        `EV_RX_BAD:   inc_of = {1'b0, rx_bad};
        `EV_TX_HDR:   inc_of = tx_replay ? 2'h0 : tx_hdr_dw;
        `EV_RX_HDR:   inc_of = rx_hdr_dw;
        `EV_FC_STALL: inc_of = {1'b0, stall_fc};
        `EV_REPLAY:   inc_of = {1'b0, tx_pkt & tx_replay};
        `EV_RB_STALL: inc_of = {1'b0, stall_rb};
        `EV_RB_UNDER: inc_of = {1'b0, tx_pkt & (retry_level < retry_th)};
        8'h2B:        inc_of = {1'b0, pc_event[0]};
        8'h2C:        inc_of = {1'b0, pc_event[1]};
        8'h2D:        inc_of = {1'b0, pc_event[2]};
        8'h2E:        inc_of = {1'b0, pc_event[3]};
        8'h2F:        inc_of = {1'b0, pc_event[4]};
        8'h30:        inc_of = {1'b0, lc_event[0]};
        8'h31:        inc_of = {1'b0, lc_event[1]};
        8'h32:        inc_of = {1'b0, lc_event[2]};
        8'h33:        inc_of = {1'b0, lc_event[3]};
        `EV_RX_DW:    inc_of = rx_dw;
        `EV_RX_MSG:   inc_of = {1'b0, rx_pkt & rx_good & (rx_kind == R_MSG)};
        `EV_RX_FUNC:  inc_of = {1'b0, rx_pkt & rx_good & (rx_kind != R_CPL)
                                & (rx_kind != R_MSG)};
        default:      inc_of = 2'h0; // 1C and unlisted codes count nothing
      endcase
    end
  endfunction

  // ****************************************************************
  // counters: bus write wins over an increment in the same cycle
  // ****************************************************************
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cnt
      wire [1:0] inc = inc_of(event_map[g*8 +: 8]);
      wire       hit = wr_go & is_cnt & (cidx == g);
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          count[g] <= {CNT_W{1'b0}};
        else if (hit)
          count[g] <= hwdata[CNT_W-1:0];
        else if (stats_enabled)
          count[g] <= count[g] + {{(CNT_W-2){1'b0}}, inc};
      end
    end
  endgenerate

endmodule // host_link_event_statistics

// file: rtl/link_stats_regs.vh
// register offsets, field positions, reset values and event codes
// assumes: included by the event statistics block, byte addresses
// ****************************************************************
// Overview of operation
// - code 0 adds transmitted TLP dwords
// - code 1 counts transmitted TLPs, no replays
// - codes 2/3 count function 0/1 packets
// - codes 4/5 count non-posted function 0/1
// - code 6 counts matching function and tag
// - code 1A counts received TLPs except messages, completions only when good
// - code 1B counts good function 0 completions
// - code 1D matches function/tag; 1C counts nothing
// - code 21 counts bad received TLPs
// - code 25 adds transmitted header dwords
// - code 26 adds received header dwords
// - code 27 counts credit stall cycles
// - code 28 counts retransmitted packets
// - code 29 counts replay buffer full stalls
// - code 2A counts packets below replay threshold
// - codes 2B-2F count partner credits crossing threshold
// - codes 30-33 count local credits reaching zero
// - code 34 adds all received dwords
// - code 35 counts good messages
// - code 36 counts good delivered requests
// - four 8-bit selection fields, counter 3 top
// - 12-bit credit thresholds, first in bits 11:0
// ****************************************************************
`ifndef LINK_STATS_REGS_VH
`define LINK_STATS_REGS_VH
// register byte offsets
`define OFS_EVENT_MAP      16'h5B14
`define OFS_THRESHOLD      16'h5B18
`define OFS_RETRY_TH       16'h5B1C
`define OFS_COUNT0         16'h5B20
`define OFS_FUNC_TAG       16'h5B40
`define OFS_LINK_CTRL_TWO  16'h5B64
// field positions
`define TH_A_LSB   0
`define TH_B_LSB   16
`define RB_TH_LSB  10
`define FT_TAG_LSB 0
`define FT_FUNC    8
// reset values
`define RST_REG    32'h00000000
// event codes
`define EV_TX_DW    8'h00
`define EV_TX_PKT   8'h01
`define EV_TX_F0    8'h02
`define EV_TX_F1    8'h03
`define EV_TX_NP0   8'h04
`define EV_TX_NP1   8'h05
`define EV_TX_FT    8'h06
`define EV_RX_PKT   8'h1A
`define EV_RX_CPL0  8'h1B
`define EV_RX_FT    8'h1D
`define EV_CLOCK    8'h20
`define EV_RX_BAD   8'h21
`define EV_TX_HDR   8'h25
`define EV_RX_HDR   8'h26
`define EV_FC_STALL 8'h27
`define EV_REPLAY   8'h28
`define EV_RB_STALL 8'h29
`define EV_RB_UNDER 8'h2A
`define EV_PC_FIRST 8'h2B
`define EV_LC_FIRST 8'h30
`define EV_RX_DW    8'h34
`define EV_RX_MSG   8'h35
`define EV_RX_FUNC  8'h36
`endif

// file: testbench/link_stats_sva.sv
// checker: bus timing and control bit of the event statistics block
// assumes: bound to the block's top module, which is the only bus slave
`timescale 1ns/1ps
module link_stats_sva (
  // bus and status
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        stats_enabled
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // accepted address phases
  wire taken = hsel && htrans[1] && hready;
  wire wr_ctl = taken && hwrite && haddr[15:0] == 16'h5B64;
  wire rd_ctl = taken && !hwrite && haddr[15:0] == 16'h5B64;
  wire rd_gap = taken && !hwrite && haddr[15:0] == 16'h5B00;
  wait_state_a: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("wait state missing");
  ready_back_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  enable_set_a: assert property (wr_ctl |=> ##1 stats_enabled == $past(hwdata[0]))
    else $error("enable bit not stored");
  enable_cause_a: assert property ($changed(stats_enabled) |-> $past(hreadyout) == 1'b0)
    else $error("enable moved without write");
  ctl_read_a: assert property (rd_ctl |=> ##1 hrdata == {31'h0, stats_enabled})
    else $error("control read wrong");
  rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved");
  gap_read_a: assert property (rd_gap |=> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // link_stats_sva

bind host_link_event_statistics link_stats_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .stats_enabled);

// file: testbench/link_port_model.sv
// link port model: drives transaction events and credit levels
// assumes: burst is called from the bench just after a clock edge
`timescale 1ns/1ps
module link_port_model (
  // clock
  input  wire         hclk,
  // transmit side
  output logic [1:0]  tx_dw = 2'h0,
  output logic [1:0]  tx_hdr_dw = 2'h0,
  output logic        tx_replay = 1'b0,
  output logic        tx_pkt = 1'b0,
  output logic [1:0]  tx_kind = 2'h0,
  output logic        tx_func = 1'b0,
  output logic [7:0]  tx_tag = 8'h0,
  output logic        stall_fc = 1'b0,
  output logic        stall_rb = 1'b0,
  output logic [5:0]  retry_level = 6'h0,
  // receive side
  output logic [1:0]  rx_dw = 2'h0,
  output logic [1:0]  rx_hdr_dw = 2'h0,
  output logic        rx_pkt = 1'b0,
  output logic [2:0]  rx_kind = 3'h0,
  output logic        rx_good = 1'b0,
  output logic        rx_func = 1'b0,
  output logic [7:0]  rx_tag = 8'h0,
  output logic        rx_bad = 1'b0,
  // credits, full when idle
  output logic [59:0] partner_credit = 60'hFFFFFFFFFFFFFFF,
  output logic [47:0] local_credit = 48'hFFFFFFFFFFFF
);
  // ****************************************************************
  // four cycle burst: np write, replay, completion, message with faults
  // ****************************************************************
  task automatic burst(input logic [7:0] t);
    tx_pkt <= 1'b1;
    tx_kind <= 2'h2;
    tx_tag <= t;
    tx_dw <= 2'h2;
    tx_hdr_dw <= 2'h2;
    partner_credit <= 60'h005005005005005;
    local_credit <= 48'h000000000000;
    @(posedge hclk);
    tx_replay <= 1'b1;
    tx_kind <= 2'h1;
    tx_func <= 1'b1;
    tx_dw <= 2'h1;
    tx_hdr_dw <= 2'h1;
    @(posedge hclk);
    {tx_pkt, tx_replay, tx_func, tx_dw, tx_hdr_dw} <= 7'h0;
    tx_tag <= ~t;
    {rx_pkt, rx_good, rx_kind, rx_func, rx_tag} <= {5'h18, 1'b0, t};
    rx_dw <= 2'h2;
    rx_hdr_dw <= 2'h1;
    @(posedge hclk);
    {rx_kind, rx_func, rx_tag, rx_dw} <= {3'h2, 1'b1, ~t, 2'h1};
    {rx_bad, stall_fc, stall_rb} <= 3'h7;
    @(posedge hclk);
    {rx_pkt, rx_good, rx_dw, rx_hdr_dw, rx_bad, stall_fc, stall_rb} <= 9'h0;
    rx_tag <= t;
    partner_credit <= 60'hFFFFFFFFFFFFFFF;
    local_credit <= 48'hFFFFFFFFFFFF;
    @(posedge hclk);
  endtask
endmodule // link_port_model

// file: testbench/tb_top.sv
// bench: register access and event counting of the statistics block
// assumes: link port model drives every event input, one bus slave
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // signals, instances, tables
  // ****************************************************************
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_phase = 0;
  logic [31:0] haddr = 0, hwdata = 0, pre [4], exp_q [$];
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  tag;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, stats_enabled, tx_replay, tx_pkt, tx_func, stall_fc;
  wire         stall_rb, rx_pkt, rx_good, rx_func, rx_bad;
  wire  [1:0]  tx_dw, tx_hdr_dw, tx_kind, rx_dw, rx_hdr_dw;
  wire  [2:0]  rx_kind;
  wire  [7:0]  tx_tag, rx_tag;
  wire  [5:0]  retry_level;
  wire  [59:0] partner_credit;
  wire  [47:0] local_credit;
  int          n_mismatch = 0, n_tests = 0, p, q, i;
  // codes mapped four at a time and the count one burst adds
  logic [7:0]  code [32] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h1A,
    8'h1B, 8'h1C, 8'h1D, 8'h21, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h30,
    8'h31, 8'h34, 8'h35, 8'h36, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h32, 8'h33, 8'h07, 8'h3F};
  logic [31:0] inc [32] = '{2, 1, 1, 0, 1, 0, 1, 1,
    1, 0, 1, 1, 2, 2, 1, 1,
    1, 2, 1, 1, 1, 3, 1, 0,
    1, 1, 1, 1, 1, 1, 0, 0};
  host_link_event_statistics u_dut (.hready(hreadyout), .*);
  link_port_model u_link (.*);
  always #12.5 hclk = ~hclk;
  // compare each finished read with the oldest noted value
  always @(posedge hclk)
    if (rd_phase && hreadyout === 1'b1) check(hrdata, exp_q.pop_front());
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: read %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for hready high at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  // one single word transfer, read value noted before its data phase
  task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d, e);
    haddr <= {16'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rd_phase <= !w;
    if (!w) exp_q.push_back(e);
    wait_rdy();
    rd_phase <= 1'b0;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(95));
    tag = 8'($urandom);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(16'h5B64, 1'b0, 0, 32'h0);
    xfer(16'h5B14, 1'b0, 0, 32'h0);
    xfer(16'h5B00, 1'b1, 32'hFFFFFFFF, 0);
    xfer(16'h5B00, 1'b0, 0, 32'h0);
    xfer(16'h5B18, 1'b1, 32'h00100010, 0);
    xfer(16'h5B1C, 1'b1, 32'h0000FC00, 0);
    xfer(16'h5B40, 1'b1, {24'h0, tag}, 0);
    for (p = 0; p < 9; p++) begin
      q = (p == 0) ? 0 : p - 1;
      if (p == 1) xfer(16'h5B64, 1'b1, 32'h1, 0);
      if (p == 1) xfer(16'h5B64, 1'b0, 0, 32'h1);
      xfer(16'h5B14, 1'b1, {code[4*q+3], code[4*q+2], code[4*q+1], code[4*q]}, 0);
      for (i = 0; i < 4; i++) begin
        pre[i] = $urandom;
        xfer(16'(16'h5B20 + 4 * i), 1'b1, pre[i], 0);
      end
      u_link.burst(tag);
      for (i = 0; i < 4; i++)
        xfer(16'(16'h5B20 + 4 * i), 1'b0, 0, pre[i] + ((p == 0) ? 32'h0 : inc[4*q+i]));
      $display("pass %0d done", p);
    end
    print_verdict();
  end
endmodule // tb_top
